// *** hdl/ubra_pkg.sv ***
// Constants for the banked register access of one UART channel.
// Assumes an 8-bit host bus with 3-bit address, one byte per access.
// Overview of operation
// RULE_01: Extended registers decoded by address plus keys
// RULE_02: Line control at 03 readable for saving
// RULE_03: Line control 80: 00/01 are divisor bytes
// RULE_04: Host restores saved line control after divisor
// RULE_05: Bank BF: 06 stop char one, 04 resume one
// RULE_06: Bank BF: 07 stop char two, 05 resume two
// RULE_07: Bank BF: 02 selects enhanced feature register
// RULE_08: Host ORs 10 into feature, then line 00
// RULE_09: Host saves modem control, adds 40
// RULE_10: Unlocked normal bank: 06 is flow threshold
// RULE_11: Unlocked normal bank: 07 is trigger level
// RULE_12: Host restores line, feature, line, modem order
// RULE_13: Host masks modem control with EF, restores
// RULE_14: Readiness enabled: read 07 returns readiness status
// RULE_15: Feature bit 4 gates upper control bit writes
// RULE_16: Threshold/trigger writes need feature4 and modem6
// RULE_17: Readiness read-only, needs modem2, no loopback
// RULE_18: Three-bit address, eight-bit registers, byte access
package ubra_pkg;
    localparam int           ADDR_W        = 3;
    localparam int           DATA_W        = 8;
    localparam logic [2:0]   OFF_DIV_LOW   = 3'h0;
    localparam logic [2:0]   OFF_DIV_HIGH  = 3'h1;
    localparam logic [2:0]   OFF_FEATURE   = 3'h2;
    localparam logic [2:0]   OFF_LINE      = 3'h3;
    localparam logic [2:0]   OFF_MODEM     = 3'h4;
    localparam logic [2:0]   OFF_RESUME1   = 3'h4;
    localparam logic [2:0]   OFF_RESUME2   = 3'h5;
    localparam logic [2:0]   OFF_STOP1     = 3'h6;
    localparam logic [2:0]   OFF_THRESH    = 3'h6;
    localparam logic [2:0]   OFF_STOP2     = 3'h7;
    localparam logic [2:0]   OFF_TRIGGER   = 3'h7;
    localparam logic [2:0]   OFF_READY     = 3'h7;
    localparam logic [7:0]   KEY_DIVISOR   = 8'h80;
    localparam logic [7:0]   KEY_FEATURE   = 8'hbf;
    localparam logic [7:0]   LINE_NORMAL   = 8'h00;
    localparam logic [7:0]   FEAT_ENH_SET  = 8'h10;
    localparam logic [7:0]   MODEM_TH_SET  = 8'h40;
    localparam logic [7:0]   MODEM_RDY_MSK = 8'hef;
    localparam logic [7:0]   MODEM_RDY_SET = 8'h04;
    localparam int           FEAT_ENH_BIT  = 4;
    localparam int           MODEM_TH_BIT  = 6;
    localparam int           MODEM_RDY_BIT = 2;
    localparam int           MODEM_LB_BIT  = 4;
    localparam logic [7:0]   MODEM_UPPER   = 8'he0;
    localparam logic [7:0]   RST_VALUE     = 8'h00;
    localparam logic [7:0]   OTHER_RD      = 8'h00;
    typedef enum logic [1:0] {
        UBRA_OP_NONE  = 2'b00,
        UBRA_OP_READ  = 2'b01,
        UBRA_OP_WRITE = 2'b10
    } ubra_op_t;
endpackage

// *** hdl/ubra_bus_if.sv ***
// Host bus between host sequencer and banked register decoder.
// Assumes one clock; a strobe is a one-cycle pulse.
`timescale 1ns/1ps
interface ubra_bus_if;
    import ubra_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr_stb;
    logic              rd_stb;
    logic [DATA_W-1:0] rdata;
    logic              rd_valid;
    modport device (input addr, input wdata, input wr_stb, input rd_stb,
                    output rdata, output rd_valid);
    modport host   (output addr, output wdata, output wr_stb, output rd_stb,
                    input rdata, input rd_valid);
endinterface

// *** hdl/ubra_device.sv ***
// Banked register decoder of one UART channel.
// Assumes single-cycle host strobes; readiness and normal-bank data come from the core.
`timescale 1ns/1ps
module ubra_device
    import ubra_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    ubra_bus_if.device        bus,
    input  wire logic [7:0]   ready_status,
    input  wire logic [7:0]   normal_rdata,
    output logic              normal_wr,
    output logic              normal_rd,
    output logic [7:0]        div_low_reg,
    output logic [7:0]        div_high_reg,
    output logic [7:0]        feature_reg,
    output logic [7:0]        line_reg,
    output logic [7:0]        modem_reg,
    output logic [7:0]        resume1_reg,
    output logic [7:0]        resume2_reg,
    output logic [7:0]        stop1_reg,
    output logic [7:0]        stop2_reg,
    output logic [7:0]        thresh_reg,
    output logic [7:0]        trigger_reg
);
    logic bank_div;
    logic bank_feat;
    logic unlock;
    logic rdy_view;
    logic wr;
    logic [7:0] rd_mux;
    logic is_normal;

    assign wr        = bus.wr_stb;
    assign bank_div  = line_reg[7] && (line_reg != KEY_FEATURE);          // [RULE_03]
    assign bank_feat = (line_reg == KEY_FEATURE);                         // [RULE_05]
    assign unlock    = feature_reg[FEAT_ENH_BIT] && modem_reg[MODEM_TH_BIT]; // [RULE_16]
    // Loopback off is required; the readiness view is read only
    assign rdy_view  = modem_reg[MODEM_RDY_BIT] && !modem_reg[MODEM_LB_BIT]; // [RULE_17]

    always_comb begin
        is_normal = 1'b0;
        rd_mux    = OTHER_RD;
        if (bus.addr == OFF_LINE) begin
            rd_mux = line_reg;                                            // [RULE_02]
        end else if (bank_feat && bus.addr == OFF_FEATURE) begin
            rd_mux = feature_reg;                                         // [RULE_07]
        end else if (bank_feat && bus.addr == OFF_RESUME1) begin
            rd_mux = resume1_reg;                                         // [RULE_05]
        end else if (bank_feat && bus.addr == OFF_RESUME2) begin
            rd_mux = resume2_reg;                                         // [RULE_06]
        end else if (bank_feat && bus.addr == OFF_STOP1) begin
            rd_mux = stop1_reg;                                           // [RULE_05]
        end else if (bank_feat && bus.addr == OFF_STOP2) begin
            rd_mux = stop2_reg;                                           // [RULE_06]
        end else if (bank_div && bus.addr == OFF_DIV_LOW) begin
            rd_mux = div_low_reg;                                         // [RULE_03]
        end else if (bank_div && bus.addr == OFF_DIV_HIGH) begin
            rd_mux = div_high_reg;                                        // [RULE_03]
        end else if (!bank_feat && bus.addr == OFF_MODEM) begin
            rd_mux = modem_reg;
        end else if (!bank_feat && unlock && bus.addr == OFF_THRESH) begin
            rd_mux = thresh_reg;                                          // [RULE_10]
        end else if (!bank_feat && rdy_view && bus.addr == OFF_READY) begin
            rd_mux = ready_status;                                        // [RULE_14]
        end else if (!bank_feat && unlock && bus.addr == OFF_TRIGGER) begin
            rd_mux = trigger_reg;                                         // [RULE_11]
        end else if (bank_feat) begin
            rd_mux = OTHER_RD;
        end else begin
            // Addresses other than line and modem, and not taken by the divisor, feature, unlocked or readiness views, select the base registers held by the core
            is_normal = 1'b1;                                             // [RULE_01]
            rd_mux    = normal_rdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus.rdata    <= RST_VALUE;
            bus.rd_valid <= 1'b0;
            normal_rd    <= 1'b0;
        end else begin
            bus.rd_valid <= bus.rd_stb;                                   // [RULE_18]
            normal_rd    <= bus.rd_stb && is_normal;
            if (bus.rd_stb) begin
                bus.rdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            line_reg <= RST_VALUE;
        end else if (wr && bus.addr == OFF_LINE) begin
            line_reg <= bus.wdata;                                        // [RULE_02]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_low_reg  <= RST_VALUE;
            div_high_reg <= RST_VALUE;
        end else if (wr && bank_div) begin
            if (bus.addr == OFF_DIV_LOW) begin
                div_low_reg <= bus.wdata;                                 // [RULE_03]
            end else if (bus.addr == OFF_DIV_HIGH) begin
                div_high_reg <= bus.wdata;                                // [RULE_03]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            feature_reg <= RST_VALUE;
            resume1_reg <= RST_VALUE;
            resume2_reg <= RST_VALUE;
            stop1_reg   <= RST_VALUE;
            stop2_reg   <= RST_VALUE;
        end else if (wr && bank_feat) begin
            if (bus.addr == OFF_FEATURE) begin
                feature_reg <= bus.wdata;                                 // [RULE_07]
            end else if (bus.addr == OFF_RESUME1) begin
                resume1_reg <= bus.wdata;                                 // [RULE_05]
            end else if (bus.addr == OFF_RESUME2) begin
                resume2_reg <= bus.wdata;                                 // [RULE_06]
            end else if (bus.addr == OFF_STOP1) begin
                stop1_reg <= bus.wdata;                                   // [RULE_05]
            end else if (bus.addr == OFF_STOP2) begin
                stop2_reg <= bus.wdata;                                   // [RULE_06]
            end
        end
    end

    // Upper modem bits hold their value unless enhanced functions are on
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            modem_reg <= RST_VALUE;
        end else if (wr && !bank_feat && bus.addr == OFF_MODEM) begin
            if (feature_reg[FEAT_ENH_BIT]) begin
                modem_reg <= bus.wdata;                                   // [RULE_15]
            end else begin
                modem_reg <= (modem_reg & MODEM_UPPER) | (bus.wdata & ~MODEM_UPPER); // [RULE_15]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            thresh_reg  <= RST_VALUE;
            trigger_reg <= RST_VALUE;
        end else if (wr && !bank_feat && unlock) begin
            if (bus.addr == OFF_THRESH) begin
                thresh_reg <= bus.wdata;                                  // [RULE_10] [RULE_16]
            end else if (bus.addr == OFF_TRIGGER) begin
                trigger_reg <= bus.wdata;                                 // [RULE_11] [RULE_16]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            normal_wr <= 1'b0;
        end else begin
            normal_wr <= wr && is_normal;
        end
    end
endmodule // ubra_device

// *** hdl/ubra_host.sv ***
// Host sequencer running the save, unlock, access and restore sequences.
// Assumes the device answers each read one cycle after the strobe.
`timescale 1ns/1ps
module ubra_host
    import ubra_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    ubra_bus_if.host          bus,
    input  wire logic         cmd_valid,
    input  wire logic [2:0]   cmd_kind,
    input  wire logic [7:0]   cmd_value1,
    input  wire logic [7:0]   cmd_value2,
    output logic              busy_reg,
    output logic              done_reg,
    output logic [7:0]        result_reg
);
    // Kinds: 0 baud, 1 chars one, 2 chars two, 3 flow mode, 4 thresh, 5 trigger, 6 ready
    typedef enum logic [1:0] {
        HST_IDLE = 2'b00,
        HST_ISSUE = 2'b01,
        HST_WAIT = 2'b10
    } ubra_host_state_t;
    ubra_host_state_t state_reg;
    logic [3:0] step_reg;
    logic [2:0] kind_reg;
    logic [7:0] v1_reg;
    logic [7:0] v2_reg;
    logic [7:0] t1_reg;
    logic [7:0] t2_reg;
    logic [7:0] t3_reg;
    logic       op_rd;
    logic [2:0] op_addr;
    logic [7:0] op_data;
    logic       op_last;

    // Each step: read or write, address, data; reads capture into temps, the ready read into the result
    always_comb begin
        op_rd = 1'b0;
        op_addr = OFF_LINE;
        op_data = RST_VALUE;
        op_last = 1'b0;
        if (kind_reg == 3'h6) begin
            case (step_reg)
                4'h0: op_rd = 1'b1;
                4'h1: op_data = (t1_reg & MODEM_RDY_MSK) | MODEM_RDY_SET; // [RULE_13]
                4'h2: begin op_rd = 1'b1; op_addr = OFF_READY; end
                default: begin op_data = t1_reg; op_last = 1'b1; end     // [RULE_13]
            endcase
            if (step_reg != 4'h2) begin
                op_addr = OFF_MODEM;
            end
        end else if (kind_reg >= 3'h4) begin
            case (step_reg)
                4'h0: op_rd = 1'b1;                                       // [RULE_02]
                4'h1: op_data = KEY_FEATURE;
                4'h2: begin op_rd = 1'b1; op_addr = OFF_FEATURE; end
                4'h3: begin op_addr = OFF_FEATURE; op_data = t2_reg | FEAT_ENH_SET; end // [RULE_08]
                4'h4: op_data = LINE_NORMAL;                              // [RULE_08]
                4'h5: begin op_rd = 1'b1; op_addr = OFF_MODEM; end        // [RULE_09]
                4'h6: begin op_addr = OFF_MODEM; op_data = t3_reg | MODEM_TH_SET; end // [RULE_09]
                4'h7: begin
                    op_addr = (kind_reg == 3'h4) ? OFF_THRESH : OFF_TRIGGER;
                    op_data = v1_reg;
                end
                4'h8: op_data = KEY_FEATURE;                              // [RULE_12]
                4'h9: begin op_addr = OFF_FEATURE; op_data = t2_reg; end  // [RULE_12]
                4'ha: op_data = t1_reg;                                   // [RULE_12]
                default: begin op_addr = OFF_MODEM; op_data = t3_reg; op_last = 1'b1; end
            endcase
        end else begin
            case (step_reg)
                4'h0: op_rd = 1'b1;                                       // [RULE_02]
                4'h1: op_data = (kind_reg == 3'h0) ? KEY_DIVISOR : KEY_FEATURE;
                4'h2: begin
                    op_data = v1_reg;
                    case (kind_reg)
                        3'h0: op_addr = OFF_DIV_LOW;
                        3'h1: op_addr = OFF_STOP1;
                        3'h2: op_addr = OFF_STOP2;
                        default: op_addr = OFF_FEATURE;
                    endcase
                end
                4'h3: begin
                    op_data = v2_reg;
                    case (kind_reg)
                        3'h0: op_addr = OFF_DIV_HIGH;
                        3'h1: op_addr = OFF_RESUME1;
                        3'h2: op_addr = OFF_RESUME2;
                        default: op_data = t1_reg;
                    endcase
                    op_last = (kind_reg == 3'h3);
                end
                default: begin op_data = t1_reg; op_last = 1'b1; end      // [RULE_04]
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg   <= HST_IDLE;
            step_reg    <= 4'h0;
            kind_reg    <= 3'h0;
            v1_reg      <= RST_VALUE;
            v2_reg      <= RST_VALUE;
            busy_reg    <= 1'b0;
            done_reg    <= 1'b0;
            bus.addr    <= OFF_LINE;
            bus.wdata   <= RST_VALUE;
            bus.wr_stb  <= 1'b0;
            bus.rd_stb  <= 1'b0;
        end else begin
            done_reg   <= 1'b0;
            bus.wr_stb <= 1'b0;
            bus.rd_stb <= 1'b0;
            case (state_reg)
                HST_IDLE: begin
                    if (cmd_valid && cmd_kind <= 3'h6) begin
                        kind_reg  <= cmd_kind;
                        v1_reg    <= cmd_value1;
                        v2_reg    <= cmd_value2;
                        step_reg  <= 4'h0;
                        busy_reg  <= 1'b1;
                        state_reg <= HST_ISSUE;
                    end
                end
                HST_ISSUE: begin
                    bus.addr   <= op_addr;
                    bus.wdata  <= op_data;
                    bus.rd_stb <= op_rd;
                    bus.wr_stb <= !op_rd;
                    state_reg  <= HST_WAIT;
                end
                default: begin
                    // Wait one cycle after a write, until read data after a read
                    if (!bus.rd_stb && (!op_rd || bus.rd_valid)) begin
                        if (op_last) begin
                            busy_reg  <= 1'b0;
                            done_reg  <= 1'b1;
                            state_reg <= HST_IDLE;
                        end else begin
                            step_reg  <= step_reg + 4'h1;
                            state_reg <= HST_ISSUE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            t1_reg     <= RST_VALUE;
            t2_reg     <= RST_VALUE;
            t3_reg     <= RST_VALUE;
            result_reg <= RST_VALUE;
        end else if (bus.rd_valid) begin
            if (step_reg == 4'h0) begin
                t1_reg <= bus.rdata;
            end else if (step_reg == 4'h2 && kind_reg == 3'h6) begin
                result_reg <= bus.rdata;
            end else if (step_reg == 4'h2) begin
                t2_reg <= bus.rdata;
            end else begin
                t3_reg <= bus.rdata;
            end
        end
    end
endmodule // ubra_host

// *** verification/ubra_bus_assertions.sv ***
// Checker on the host bus between host sequencer and device.
// Assumes one clock, synchronous active-low reset, and the host as the only bus driver.
`timescale 1ns/1ps
module ubra_bus_assertions
    import ubra_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wr_stb,
    input wire logic              rd_stb,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              rd_valid
);
    logic [7:0] line_sh;
    logic [7:0] feat_sh;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Line control is writable in every bank
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            line_sh <= RST_VALUE;
        end else if (wr_stb && addr == OFF_LINE) begin
            line_sh <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            feat_sh <= RST_VALUE;
        end else if (wr_stb && addr == OFF_FEATURE && line_sh == KEY_FEATURE) begin
            feat_sh <= wdata;
        end
    end

    one_strobe_a: assert property (!(wr_stb && rd_stb))
        else $error("read and write strobe together");
    read_answer_a: assert property (rd_stb |=> rd_valid)
        else $error("read not answered next cycle");
    valid_cause_a: assert property (rd_valid |-> $past(rd_stb))
        else $error("read valid without a read");
    valid_pulse_a: assert property (rd_valid && !rd_stb |=> !rd_valid)
        else $error("read valid longer than one cycle");
    rdata_hold_a: assert property (!rd_stb |=> $stable(rdata))
        else $error("read data changed without a read");
    line_read_a: assert property (rd_stb && addr == OFF_LINE |=> rdata == line_sh)
        else $error("line control read wrong");
    feature_read_a: assert property (rd_stb && addr == OFF_FEATURE && line_sh == KEY_FEATURE
        |=> rdata == feat_sh)
        else $error("feature register read wrong");
    // Excluding restores from the divisor or feature bank keeps only the entry write
    divisor_seq_a: assert property (wr_stb && addr == OFF_LINE && wdata == KEY_DIVISOR
        && line_sh != KEY_DIVISOR && line_sh != KEY_FEATURE
        |-> ##2 (wr_stb && addr == OFF_DIV_LOW) ##2 (wr_stb && addr == OFF_DIV_HIGH)
        ##2 (wr_stb && addr == OFF_LINE))
        else $error("divisor sequence out of order");
    // Read data still holds the saved value when the unlock write follows
    enh_unlock_a: assert property (wr_stb && $past(rd_stb, 3) && $past(addr, 3) == OFF_FEATURE
        && line_sh == KEY_FEATURE
        |-> (addr == OFF_FEATURE && wdata == (rdata | FEAT_ENH_SET))
        ##2 (wr_stb && addr == OFF_LINE && wdata == LINE_NORMAL))
        else $error("enhanced enable sequence out of order");
    modem_unlock_a: assert property (rd_stb && addr == OFF_MODEM && $past(wr_stb, 2)
        && $past(addr, 2) == OFF_LINE && $past(wdata, 2) == LINE_NORMAL
        |=> ##2 (wr_stb && addr == OFF_MODEM && wdata == (rdata | MODEM_TH_SET)))
        else $error("modem access sequence out of order");
endmodule // ubra_bus_assertions

// *** verification/uart_banked_register_access_tb_top.sv ***
// Testbench: host sequencer against one device, and a second device driven directly.
// Assumes package, bus interface and both design modules compiled first.
`timescale 1ns/1ps
module uart_banked_register_access_tb_top;
    import ubra_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       cmd_valid = 1'b0;
    logic [2:0] cmd_kind = 3'h0;
    logic [7:0] cmd_value1 = 8'h00;
    logic [7:0] cmd_value2 = 8'h00;
    logic [7:0] ready_status = 8'ha5;
    logic [7:0] normal_rdata = 8'h3c;
    logic       busy;
    logic       done;
    logic [7:0] result;
    logic [7:0] rd;
    logic       nwr_b;
    logic       nrd_b;
    logic [7:0] ra [11];
    logic [7:0] rb [11];
    int         n_fail = 0;
    int         samples_checked = 0;

    ubra_bus_if bus_a ();
    ubra_bus_if bus_b ();

    always #25 clk = ~clk;

    ubra_host ubra_host_inst (.clk(clk), .rst_n(rst_n), .bus(bus_a.host),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_value1(cmd_value1),
        .cmd_value2(cmd_value2), .busy_reg(busy), .done_reg(done), .result_reg(result));
    ubra_device ubra_device_inst (.clk(clk), .rst_n(rst_n), .bus(bus_a.device),
        .ready_status(ready_status), .normal_rdata(normal_rdata), .normal_wr(), .normal_rd(),
        .div_low_reg(ra[0]), .div_high_reg(ra[1]), .feature_reg(ra[2]), .line_reg(ra[3]),
        .modem_reg(ra[4]), .resume1_reg(ra[5]), .resume2_reg(ra[6]), .stop1_reg(ra[7]),
        .stop2_reg(ra[8]), .thresh_reg(ra[9]), .trigger_reg(ra[10]));
    // Second device lets the bench break the host's ordering on purpose
    ubra_device ubra_device_inst_b (.clk(clk), .rst_n(rst_n), .bus(bus_b.device),
        .ready_status(ready_status), .normal_rdata(normal_rdata), .normal_wr(nwr_b),
        .normal_rd(nrd_b),
        .div_low_reg(rb[0]), .div_high_reg(rb[1]), .feature_reg(rb[2]), .line_reg(rb[3]),
        .modem_reg(rb[4]), .resume1_reg(rb[5]), .resume2_reg(rb[6]), .stop1_reg(rb[7]),
        .stop2_reg(rb[8]), .thresh_reg(rb[9]), .trigger_reg(rb[10]));
    ubra_bus_assertions ubra_bus_assertions_inst (.clk(clk), .rst_n(rst_n),
        .addr(bus_a.addr), .wdata(bus_a.wdata), .wr_stb(bus_a.wr_stb),
        .rd_stb(bus_a.rd_stb), .rdata(bus_a.rdata), .rd_valid(bus_a.rd_valid));

    task automatic report_and_stop();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic give_up();
        n_fail++;
        report_and_stop();
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bwr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_b.addr <= a;
        bus_b.wdata <= d;
        bus_b.wr_stb <= 1'b1;
        @(posedge clk);
        bus_b.wr_stb <= 1'b0;
        #1;
    endtask

    // Read answer is due exactly one cycle after the strobe
    task automatic brd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_b.addr <= a;
        bus_b.rd_stb <= 1'b1;
        @(posedge clk);
        bus_b.rd_stb <= 1'b0;
        #1;
        if (bus_b.rd_valid !== 1'b1) give_up();
        d = bus_b.rdata;
    endtask

    task automatic run(input logic [2:0] k, input logic [7:0] v1, input logic [7:0] v2);
        int i;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        cmd_value1 <= v1;
        cmd_value2 <= v2;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
        chk({7'h00, busy}, 8'h01);
        for (i = 0; i < 100 && done !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 100) give_up();
    endtask

    initial begin
        bus_b.addr = 3'h0;
        bus_b.wdata = 8'h00;
        bus_b.wr_stb = 1'b0;
        bus_b.rd_stb = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        for (int i = 0; i < 11; i++) chk(rb[i], RST_VALUE);
        run(3'h0, 8'h12, 8'h34);
        chk(ra[0], 8'h12);
        chk(ra[1], 8'h34);
        chk(ra[3], 8'h00);
        run(3'h1, 8'h56, 8'h78);
        chk(ra[7], 8'h56);
        chk(ra[5], 8'h78);
        run(3'h2, 8'h9a, 8'hbc);
        chk(ra[8], 8'h9a);
        chk(ra[6], 8'hbc);
        run(3'h3, 8'h0a, 8'h00);
        chk(ra[2], 8'h0a);
        run(3'h4, 8'hc4, 8'h00);
        chk(ra[9], 8'hc4);
        chk(ra[2], 8'h0a);
        // Feature is restored before modem, so the locked upper modem bits keep 40
        chk(ra[4], 8'h40);
        run(3'h5, 8'h5b, 8'h00);
        chk(ra[10], 8'h5b);
        chk(ra[3], 8'h00);
        run(3'h6, 8'h00, 8'h00);
        chk(result, 8'ha5);
        chk(ra[4], 8'h40);
        bwr(OFF_LINE, 8'h03);
        brd(OFF_LINE, rd);
        chk(rd, 8'h03);
        chk({7'h00, nrd_b}, 8'h00);
        brd(OFF_DIV_LOW, rd);
        chk(rd, normal_rdata);
        chk({7'h00, nrd_b}, 8'h01);
        bwr(OFF_DIV_LOW, 8'h77);
        chk({7'h00, nwr_b}, 8'h01);
        chk(rb[0], 8'h00);
        bwr(OFF_LINE, KEY_DIVISOR);
        bwr(OFF_DIV_LOW, 8'h11);
        brd(OFF_DIV_LOW, rd);
        chk(rd, 8'h11);
        bwr(OFF_LINE, KEY_FEATURE);
        brd(OFF_DIV_LOW, rd);
        chk(rd, 8'h00);
        bwr(OFF_FEATURE, 8'h00);
        bwr(OFF_LINE, LINE_NORMAL);
        bwr(OFF_MODEM, 8'he4);
        chk(rb[4], 8'h04);
        bwr(OFF_THRESH, 8'h33);
        chk(rb[9], 8'h00);
        brd(OFF_READY, rd);
        chk(rd, ready_status);
        bwr(OFF_LINE, KEY_FEATURE);
        bwr(OFF_FEATURE, FEAT_ENH_SET);
        bwr(OFF_LINE, LINE_NORMAL);
        bwr(OFF_MODEM, 8'h40);
        bwr(OFF_THRESH, 8'h33);
        chk(rb[9], 8'h33);
        bwr(OFF_TRIGGER, 8'h66);
        chk(rb[10], 8'h66);
        // Loopback on hides the readiness view again
        bwr(OFF_MODEM, 8'hd4);
        chk(rb[4], 8'hd4);
        brd(OFF_READY, rd);
        chk(rd, 8'h66);
        report_and_stop();
    end
endmodule // uart_banked_register_access_tb_top
